// ---- src/dmr_cmd_decode.sv ----
// Purpose: Decodes a mode-register-set command into a register select
// Assumes: Pins already synchronised, active-low command strobes
// Notes: Output is registered
`timescale 1ns/10ps
`include "dmr_map.svh"
module dmr_cmd_decode
  import dmr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [2:0] bank_i,
  output dmr_sel_t sel_o
);
  typedef struct packed {dmr_sel_t sel;} dmr_dec_t;
  dmr_dec_t st_reg;
  dmr_dec_t st_next;
  always_comb begin
    st_next.sel = DMR_SEL_NONE;
    if (!cs_n_i && !ras_n_i && !cas_n_i && !we_n_i) begin
      unique case (bank_i)
        `DMR_BANK_MR1: st_next.sel = DMR_SEL_MR1;
        `DMR_BANK_MR2: st_next.sel = DMR_SEL_MR2;
        `DMR_BANK_MR3: st_next.sel = DMR_SEL_MR3;
        default: st_next.sel = DMR_SEL_NONE;
      endcase
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg <= '{sel: DMR_SEL_NONE};
    end else begin
      st_reg <= st_next;
    end
  end
  assign sel_o = st_reg.sel;
endmodule : dmr_cmd_decode

// ---- src/dmr_map.svh ----
// Purpose: Constants for the mode register decode block
// Assumes: Command pins are sampled on the system clock
// Notes: Field positions are address bit numbers
`ifndef DMR_MAP_SVH
`define DMR_MAP_SVH
`define DMR_ADDR_W 16
`define DMR_BANK_W 3
`define DMR_BANK_MR1 3'h1
`define DMR_BANK_MR2 3'h2
`define DMR_BANK_MR3 3'h3
`define DMR_MR1_WLEVEL 7
`define DMR_MR1_TSTROBE 11
`define DMR_MR1_QOFF 12
`define DMR_MR2_CWL_LO 3
`define DMR_MR2_CWL_HI 5
`define DMR_MR2_SRT 7
`define DMR_MR2_RTTWR_LO 9
`define DMR_MR2_RTTWR_HI 10
`define DMR_MR3_LOC_LO 0
`define DMR_MR3_LOC_HI 1
`define DMR_MR3_MPR_EN 2
`define DMR_MR_RESET 16'h0000
`define DMR_CWL_BASE 4'h5
`define DMR_SR_DIV_1X 16'h0186
`define DMR_SR_DIV_2X 16'h00C3
`define DMR_MPR_PATTERN 8'h55
`endif

// ---- src/dmr_pkg.sv ----
// Purpose: Types for the mode register decode block
// Assumes: Constants come from dmr_map.svh
// Notes: Register state is kept as one struct per module
package dmr_pkg;
  typedef enum logic [1:0] {DMR_SEL_NONE, DMR_SEL_MR1, DMR_SEL_MR2, DMR_SEL_MR3} dmr_sel_t;
  typedef struct packed {
    logic [15:0] mode_register_one;
    logic [15:0] mode_register_two;
    logic [15:0] mode_register_three;
  } dmr_regs_t;
endpackage : dmr_pkg

// ---- src/dmr_sr_tick.sv ----
// Purpose: Self-refresh tick divider, 1x or 2x rate
// Assumes: One clock domain
// Notes: Rate change takes effect at once; the running count is compared with the new limit
`timescale 1ns/10ps
`include "dmr_map.svh"
module dmr_sr_tick
  import dmr_pkg::*;
#(
  parameter logic [15:0] DIV_1X = `DMR_SR_DIV_1X,
  parameter logic [15:0] DIV_2X = `DMR_SR_DIV_2X
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic double_i,
  output logic tick_o
);
  typedef struct packed {logic [15:0] cnt; logic tick;} dmr_tick_t;
  dmr_tick_t st_reg;
  dmr_tick_t st_next;
  logic [15:0] limit;
  always_comb begin
    limit = double_i ? DIV_2X : DIV_1X;
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!enable_i) begin
      st_next.cnt = 16'h0000;
    end else if (st_reg.cnt >= limit - 16'h0001) begin
      st_next.cnt = 16'h0000;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_reg <= '{cnt: 16'h0000, tick: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick_o = st_reg.tick;
endmodule : dmr_sr_tick

// ---- src/dmr_top.sv ----
// Function
// - Output disable bit floats data and strobes; TERMINATION_STROBE_EN_O is not gated by it, only the complement
// - Termination strobe enable replaces write masking
// - Termination strobe never carries read strobe
// - Termination strobe only in x8 organisation
// - Command with bank two loads register two
// - Register two bits 5:3 select write latency
// - Write latency equals additive plus write latency
// - Only whole-clock latencies are supported
// - Register two bits 10:9 set write termination
// - No dynamic termination during write leveling
// - Write termination works without nominal termination
// - Register two bit 7 enables temperature mode
// - Temperature mode doubles self-refresh rate
// - Command with bank three loads register three
// - Readout location ignored when readout disabled
// - Readout enabled returns predefined read pattern
// - Command with bank one loads register one
// Purpose: Mode register one/two/three store and decode
// Assumes: Command and address pins come from another domain
// Notes: Latencies are counted in whole clocks only
`timescale 1ns/10ps
`include "dmr_map.svh"
module dmr_top
  import dmr_pkg::*;
#(
  parameter bit IS_X8 = 1'b1,
  parameter logic [15:0] SR_DIV_1X = `DMR_SR_DIV_1X,
  parameter logic [15:0] SR_DIV_2X = `DMR_SR_DIV_2X
) (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [2:0] BANK_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [3:0] ADDITIVE_LATENCY_I,
  input wire logic WRITE_ACTIVE_I,
  input wire logic READ_ACTIVE_I,
  input wire logic SELF_REFRESH_I,
  input wire logic WRITE_DATA_MASK_I,
  output logic OUTPUT_DRIVE_EN_N_O,
  output logic WRITE_MASK_ENABLE_O,
  output logic MASKED_BYTE_O,
  output logic TERMINATION_STROBE_EN_O,
  output logic TERMINATION_STROBE_COMPLEMENT_EN_O,
  output logic WRITE_LEVELING_O,
  output logic [3:0] WRITE_CAS_LATENCY_O,
  output logic [4:0] WRITE_LATENCY_O,
  output logic [1:0] WRITE_TERMINATION_O,
  output logic DYN_TERM_ACTIVE_O,
  output logic SELF_REFRESH_TEMP_MODE_O,
  output logic SELF_REFRESH_TICK_O,
  output logic MULTIPURPOSE_READOUT_O,
  output logic [1:0] READOUT_LOCATION_O,
  output logic [7:0] READ_DATA_O,
  output logic READ_DATA_VALID_O
);
  typedef struct packed {
    logic [1:0] cs_n_s;
    logic [1:0] ras_n_s;
    logic [1:0] cas_n_s;
    logic [1:0] we_n_s;
    logic [5:0] bank_s;
    logic [31:0] addr_s;
    logic [1:0] wr_s;
    logic [1:0] rd_s;
    logic [1:0] sr_s;
    logic [1:0] dm_s;
    logic [15:0] addr_hold;
    dmr_regs_t regs;
    logic out_en_n;
    logic wmask_en;
    logic masked;
    logic ts_en;
    logic tsc_en;
    logic wlevel;
    logic [3:0] write_cas_latency;
    logic [4:0] wl;
    logic [1:0] rtt_wr;
    logic dyn_term;
    logic self_refresh_temp_mode;
    logic sr_tick;
    logic multipurpose_readout;
    logic [1:0] mpr_loc;
    logic [7:0] rdata;
    logic rvalid;
  } dmr_state_t;

  dmr_state_t st_reg;
  dmr_state_t st_next;
  dmr_sel_t sel;
  logic tick;
  logic [15:0] mr1;
  logic [15:0] mr2;
  logic [15:0] mr3;

  // Two-stage synchronisers; second stage is the only reader of the first
  dmr_cmd_decode u_dec (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .cs_n_i(st_reg.cs_n_s[1]),
    .ras_n_i(st_reg.ras_n_s[1]),
    .cas_n_i(st_reg.cas_n_s[1]),
    .we_n_i(st_reg.we_n_s[1]),
    .bank_i(st_reg.bank_s[5:3]),
    .sel_o(sel)
  );

  dmr_sr_tick #(
    .DIV_1X(SR_DIV_1X),
    .DIV_2X(SR_DIV_2X)
  ) u_tick (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .enable_i(st_reg.sr_s[1]),
    .double_i(st_reg.self_refresh_temp_mode),
    .tick_o(tick)
  );

  assign mr1 = st_reg.regs.mode_register_one;
  assign mr2 = st_reg.regs.mode_register_two;
  assign mr3 = st_reg.regs.mode_register_three;

  always_comb begin
    st_next = st_reg;
    st_next.cs_n_s = {st_reg.cs_n_s[0], CS_N_I};
    st_next.ras_n_s = {st_reg.ras_n_s[0], RAS_N_I};
    st_next.cas_n_s = {st_reg.cas_n_s[0], CAS_N_I};
    st_next.we_n_s = {st_reg.we_n_s[0], WE_N_I};
    st_next.bank_s = {st_reg.bank_s[2:0], BANK_I};
    st_next.addr_s = {st_reg.addr_s[15:0], ADDR_I};
    st_next.wr_s = {st_reg.wr_s[0], WRITE_ACTIVE_I};
    st_next.rd_s = {st_reg.rd_s[0], READ_ACTIVE_I};
    st_next.sr_s = {st_reg.sr_s[0], SELF_REFRESH_I};
    st_next.dm_s = {st_reg.dm_s[0], WRITE_DATA_MASK_I};
    // Address aligned with the one-cycle decoder delay
    st_next.addr_hold = st_reg.addr_s[31:16];
    // Only the addressed register changes; others hold
    unique case (sel)
      DMR_SEL_MR1: st_next.regs.mode_register_one = st_reg.addr_hold;
      DMR_SEL_MR2: st_next.regs.mode_register_two = st_reg.addr_hold;
      DMR_SEL_MR3: st_next.regs.mode_register_three = st_reg.addr_hold;
      DMR_SEL_NONE: st_next.regs = st_reg.regs;
    endcase

    // Output disable masks read data and the strobe complement, not the termination strobe
    st_next.out_en_n = mr1[`DMR_MR1_QOFF];
    st_next.wlevel = mr1[`DMR_MR1_WLEVEL];
    // Shared pin: strobe mode wins over masking, x8 only
    st_next.ts_en = IS_X8 && mr1[`DMR_MR1_TSTROBE];
    st_next.tsc_en = IS_X8 && mr1[`DMR_MR1_TSTROBE] && !mr1[`DMR_MR1_QOFF];
    st_next.wmask_en = !(IS_X8 && mr1[`DMR_MR1_TSTROBE]);
    st_next.masked = st_next.wmask_en && st_reg.wr_s[1] && st_reg.dm_s[1];

    // Field code plus base gives cycles; no half-clock encodings exist
    st_next.write_cas_latency = `DMR_CWL_BASE + {1'b0, mr2[`DMR_MR2_CWL_HI:`DMR_MR2_CWL_LO]};
    st_next.wl = {1'b0, ADDITIVE_LATENCY_I} + {1'b0, st_next.write_cas_latency};

    st_next.rtt_wr = mr2[`DMR_MR2_RTTWR_HI:`DMR_MR2_RTTWR_LO];
    // Write termination independent of nominal; off in leveling
    st_next.dyn_term = st_reg.wr_s[1] && (st_next.rtt_wr != 2'h0) && !mr1[`DMR_MR1_WLEVEL];

    st_next.self_refresh_temp_mode = mr2[`DMR_MR2_SRT];
    st_next.sr_tick = tick;

    st_next.multipurpose_readout = mr3[`DMR_MR3_MPR_EN];
    // Location forced to zero when readout is off
    st_next.mpr_loc = mr3[`DMR_MR3_MPR_EN] ? mr3[`DMR_MR3_LOC_HI:`DMR_MR3_LOC_LO] : 2'h0;
    // Pattern is data, not a strobe; masked when outputs are off
    st_next.rvalid = st_reg.rd_s[1] && st_reg.multipurpose_readout && !st_reg.out_en_n;
    st_next.rdata = st_next.rvalid ? `DMR_MPR_PATTERN : 8'h00;
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st_reg <= '0;
      st_reg.cs_n_s <= 2'h3;
      st_reg.ras_n_s <= 2'h3;
      st_reg.cas_n_s <= 2'h3;
      st_reg.we_n_s <= 2'h3;
      st_reg.regs <= {`DMR_MR_RESET, `DMR_MR_RESET, `DMR_MR_RESET};
      st_reg.wmask_en <= 1'b1;
      st_reg.write_cas_latency <= `DMR_CWL_BASE;
      st_reg.wl <= {1'b0, `DMR_CWL_BASE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign OUTPUT_DRIVE_EN_N_O = st_reg.out_en_n;
  assign WRITE_MASK_ENABLE_O = st_reg.wmask_en;
  assign MASKED_BYTE_O = st_reg.masked;
  assign TERMINATION_STROBE_EN_O = st_reg.ts_en;
  assign TERMINATION_STROBE_COMPLEMENT_EN_O = st_reg.tsc_en;
  assign WRITE_LEVELING_O = st_reg.wlevel;
  assign WRITE_CAS_LATENCY_O = st_reg.write_cas_latency;
  assign WRITE_LATENCY_O = st_reg.wl;
  assign WRITE_TERMINATION_O = st_reg.rtt_wr;
  assign DYN_TERM_ACTIVE_O = st_reg.dyn_term;
  assign SELF_REFRESH_TEMP_MODE_O = st_reg.self_refresh_temp_mode;
  assign SELF_REFRESH_TICK_O = st_reg.sr_tick;
  assign MULTIPURPOSE_READOUT_O = st_reg.multipurpose_readout;
  assign READOUT_LOCATION_O = st_reg.mpr_loc;
  assign READ_DATA_O = st_reg.rdata;
  assign READ_DATA_VALID_O = st_reg.rvalid;
endmodule : dmr_top

// ---- test/dmr_ctrl_model.sv ----
// Purpose: Controller side issuing mode-register-set commands
// Assumes: One request pulse per command, spaced by the bench
// Notes: Idle address and bank show inverted junk, not stale values
`timescale 1ns/10ps
module dmr_ctrl_model (
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [2:0] bank_i,
  input wire logic [15:0] addr_i,
  output logic cmd_n_o = 1'b1,
  output logic [2:0] bank_o = 3'h0,
  output logic [15:0] addr_o = 16'h0000
);
  logic [15:0] keep;
  always_comb begin
    keep = 16'hFFFF;
    if (bank_i == 3'h2) keep = 16'h06FF;
    if (bank_i == 3'h3) keep = 16'h0007;
  end
  always @(posedge clock_i) begin
    cmd_n_o <= !go_i;
    bank_o <= go_i ? bank_i : ~bank_o;
    addr_o <= go_i ? (addr_i & keep) : ~addr_o;
  end
endmodule : dmr_ctrl_model

// ---- test/dmr_top_chk.sv ----
// Purpose: Port assertions for the mode register decode block
// Assumes: Commands spaced well apart, outputs settle six edges on
// Notes: Strobe and mask always differ, in either organisation
`timescale 1ns/10ps
`include "dmr_map.svh"
module dmr_top_chk (
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic CS_N_I,
  input wire logic RAS_N_I,
  input wire logic CAS_N_I,
  input wire logic WE_N_I,
  input wire logic [2:0] BANK_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [3:0] ADDITIVE_LATENCY_I,
  input wire logic OUTPUT_DRIVE_EN_N_O,
  input wire logic WRITE_MASK_ENABLE_O,
  input wire logic TERMINATION_STROBE_EN_O,
  input wire logic WRITE_LEVELING_O,
  input wire logic [3:0] WRITE_CAS_LATENCY_O,
  input wire logic [4:0] WRITE_LATENCY_O,
  input wire logic DYN_TERM_ACTIVE_O,
  input wire logic SELF_REFRESH_TEMP_MODE_O,
  input wire logic MULTIPURPOSE_READOUT_O,
  input wire logic [7:0] READ_DATA_O,
  input wire logic READ_DATA_VALID_O
);
  logic mrs;
  assign mrs = !(CS_N_I | RAS_N_I | CAS_N_I | WE_N_I);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  AST_QOFF: assert property (mrs && BANK_I == 3'h1 |-> ##6
    OUTPUT_DRIVE_EN_N_O == $past(ADDR_I[12], 6)) else $error("output disable wrong");
  AST_CWL: assert property (mrs && BANK_I == 3'h2 |-> ##6
    WRITE_CAS_LATENCY_O == `DMR_CWL_BASE + $past(ADDR_I[5:3], 6)) else $error("cwl wrong");
  AST_SRT: assert property (mrs && BANK_I == 3'h2 |-> ##6
    SELF_REFRESH_TEMP_MODE_O == $past(ADDR_I[7], 6)) else $error("temp mode wrong");
  AST_MPR: assert property (mrs && BANK_I == 3'h3 |-> ##6
    MULTIPURPOSE_READOUT_O == $past(ADDR_I[2], 6)) else $error("readout wrong");
  AST_SHARE: assert property (WRITE_MASK_ENABLE_O != TERMINATION_STROBE_EN_O)
    else $error("mask and strobe overlap");
  AST_WL: assert property (($stable(ADDITIVE_LATENCY_I) && $stable(WRITE_CAS_LATENCY_O))[*3]
    |-> WRITE_LATENCY_O == ADDITIVE_LATENCY_I + WRITE_CAS_LATENCY_O) else $error("wl wrong");
  AST_LEVEL: assert property (WRITE_LEVELING_O [*3] |-> !DYN_TERM_ACTIVE_O)
    else $error("dynamic term in leveling");
  AST_PATTERN: assert property (READ_DATA_VALID_O |-> READ_DATA_O == `DMR_MPR_PATTERN)
    else $error("readout pattern wrong");
endmodule : dmr_top_chk
bind dmr_top dmr_top_chk chk_u (.*);

// ---- test/dram_mode_register_decode_test.sv ----
// Purpose: Self-checking bench for the mode register decode block
// Assumes: Commands spaced ten clocks apart
// Notes: Self-refresh dividers shortened to 8 and 4 clocks
`timescale 1ns/10ps
`include "dmr_map.svh"
module dram_mode_register_decode_test;
  logic CLOCK_I = 1'b0, RST_I = 1'b1, WRITE_ACTIVE_I = 1'b0, READ_ACTIVE_I = 1'b0;
  logic SELF_REFRESH_I = 1'b0, WRITE_DATA_MASK_I = 1'b0, go = 1'b0, we_hi = 1'b0, cmd_n;
  logic x4_ts, x4_wmask;
  logic [3:0] ADDITIVE_LATENCY_I = 4'h0, WRITE_CAS_LATENCY_O;
  logic [2:0] BANK_I, gbank = 3'h0;
  logic [15:0] ADDR_I, gaddr = 16'h0000, a, m1;
  logic OUTPUT_DRIVE_EN_N_O, WRITE_MASK_ENABLE_O, MASKED_BYTE_O, TERMINATION_STROBE_EN_O;
  logic TERMINATION_STROBE_COMPLEMENT_EN_O, WRITE_LEVELING_O, DYN_TERM_ACTIVE_O;
  logic SELF_REFRESH_TEMP_MODE_O, SELF_REFRESH_TICK_O, MULTIPURPOSE_READOUT_O;
  logic READ_DATA_VALID_O;
  logic [4:0] WRITE_LATENCY_O;
  logic [1:0] WRITE_TERMINATION_O, READOUT_LOCATION_O;
  logic [7:0] READ_DATA_O;
  wire CS_N_I = cmd_n, RAS_N_I = cmd_n, CAS_N_I = cmd_n, WE_N_I = cmd_n | we_hi;
  int fail_count = 0, n_tests = 0, t_c = 0, ct [2];
  dmr_ctrl_model ctrl_u (.clock_i(CLOCK_I), .go_i(go), .bank_i(gbank), .addr_i(gaddr),
    .cmd_n_o(cmd_n), .bank_o(BANK_I), .addr_o(ADDR_I));
  dmr_top #(.SR_DIV_1X(16'h0008), .SR_DIV_2X(16'h0004)) dut_u (.*);
  // Second copy in the narrow organisation: strobe must never appear
  dmr_top #(.IS_X8(1'b0)) x4_u (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CS_N_I(CS_N_I),
    .RAS_N_I(RAS_N_I), .CAS_N_I(CAS_N_I), .WE_N_I(WE_N_I), .BANK_I(BANK_I), .ADDR_I(ADDR_I),
    .ADDITIVE_LATENCY_I(ADDITIVE_LATENCY_I), .WRITE_ACTIVE_I(WRITE_ACTIVE_I),
    .READ_ACTIVE_I(READ_ACTIVE_I), .SELF_REFRESH_I(SELF_REFRESH_I),
    .WRITE_DATA_MASK_I(WRITE_DATA_MASK_I), .OUTPUT_DRIVE_EN_N_O(),
    .WRITE_MASK_ENABLE_O(x4_wmask), .MASKED_BYTE_O(), .TERMINATION_STROBE_EN_O(x4_ts),
    .TERMINATION_STROBE_COMPLEMENT_EN_O(), .WRITE_LEVELING_O(), .WRITE_CAS_LATENCY_O(),
    .WRITE_LATENCY_O(), .WRITE_TERMINATION_O(), .DYN_TERM_ACTIVE_O(),
    .SELF_REFRESH_TEMP_MODE_O(), .SELF_REFRESH_TICK_O(), .MULTIPURPOSE_READOUT_O(),
    .READOUT_LOCATION_O(), .READ_DATA_O(), .READ_DATA_VALID_O());
  initial begin
    forever #10 CLOCK_I = ~CLOCK_I;
  end
  task automatic chk(input string n, input logic [15:0] e, s);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [15:0] exp_wl(input int al, input int code);
    return 16'(`DMR_CWL_BASE + al + code);
  endfunction : exp_wl
  function automatic logic [15:0] exp_loc(input int v);
    return v[2] ? 16'(v[1:0]) : 16'h0000;
  endfunction : exp_loc
  // Hot parts need two or four times the external refresh rate
  function automatic int refi_ns(input int temp);
    return (temp > 95) ? 1950 : (temp > 85) ? 3900 : 2 * 3900;
  endfunction : refi_ns
  task automatic mrs(input logic [2:0] b, input logic [15:0] v);
    @(posedge CLOCK_I);
    go <= 1'b1;
    gbank <= b;
    gaddr <= v;
    @(posedge CLOCK_I);
    go <= 1'b0;
    repeat (8) @(posedge CLOCK_I);
  endtask : mrs
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Whole run is about 550 clocks; generous margin
  initial begin
    repeat (5000) @(posedge CLOCK_I);
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hC57950C1));
    repeat (10) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    repeat (2) @(posedge CLOCK_I);
    chk("wmask_rst", 16'h1, WRITE_MASK_ENABLE_O);
    chk("wl_rst", 16'h5, WRITE_LATENCY_O);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      m1 = 16'($urandom);
      // Leveling only with outputs off, so any nominal termination is legal
      m1[12] = m1[12] | m1[7];
      mrs(3'h1, m1);
      chk("qoff", m1[12], OUTPUT_DRIVE_EN_N_O);
      chk("tstrobe", m1[11], TERMINATION_STROBE_EN_O);
      chk("wmask", !m1[11], WRITE_MASK_ENABLE_O);
      chk("tstrobe_c", m1[11] & !m1[12], TERMINATION_STROBE_COMPLEMENT_EN_O);
      chk("wlevel", m1[7], WRITE_LEVELING_O);
      chk("x4_tstrobe", 16'h0, x4_ts);
      chk("x4_wmask", 16'h1, x4_wmask);
    end
    $display("test mode_register_one done");
    for (int i = 0; i < 8; i++) begin
      ADDITIVE_LATENCY_I <= 4'($urandom_range(10));
      a = (16'($urandom) & 16'h0680) | 16'(i << 3);
      mrs(3'h2, a);
      chk("cwl", 16'(`DMR_CWL_BASE + i), WRITE_CAS_LATENCY_O);
      chk("wl", exp_wl(ADDITIVE_LATENCY_I, i), WRITE_LATENCY_O);
      chk("srt", a[7], SELF_REFRESH_TEMP_MODE_O);
      chk("wterm", a[10:9], WRITE_TERMINATION_O);
      chk("qoff_hold", m1[12], OUTPUT_DRIVE_EN_N_O);
    end
    mrs(3'h0, 16'hFFFF);
    mrs(3'h6, 16'hFFFF);
    chk("refuse_srt", a[7], SELF_REFRESH_TEMP_MODE_O);
    chk("refuse_qoff", m1[12], OUTPUT_DRIVE_EN_N_O);
    // Write strobe high makes it some other command, not a register load
    we_hi <= 1'b1;
    mrs(3'h2, 16'h0000);
    we_hi <= 1'b0;
    chk("refuse_we", a[10:9], WRITE_TERMINATION_O);
    $display("test mode_register_two done");
    mrs(3'h1, 16'h0000);
    mrs(3'h2, 16'h0200);
    WRITE_ACTIVE_I <= 1'b1;
    WRITE_DATA_MASK_I <= 1'b1;
    repeat (5) @(posedge CLOCK_I);
    chk("dyn", 16'h1, DYN_TERM_ACTIVE_O);
    chk("masked", 16'h1, MASKED_BYTE_O);
    mrs(3'h1, 16'h1880);
    chk("dyn_lvl", 16'h0, DYN_TERM_ACTIVE_O);
    chk("masked_ts", 16'h0, MASKED_BYTE_O);
    WRITE_ACTIVE_I <= 1'b0;
    mrs(3'h1, 16'h0000);
    $display("test write done");
    READ_ACTIVE_I <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      mrs(3'h3, 16'(i));
      chk("loc", exp_loc(i), READOUT_LOCATION_O);
      chk("mpr", 16'(i[2]), MULTIPURPOSE_READOUT_O);
      chk("rvalid", 16'(i[2]), READ_DATA_VALID_O);
      chk("rdata", i[2] ? 16'(`DMR_MPR_PATTERN) : 16'h0, READ_DATA_O);
    end
    mrs(3'h1, 16'h1000);
    chk("rd_qoff", 16'h0, READ_DATA_VALID_O);
    READ_ACTIVE_I <= 1'b0;
    $display("test readout done");
    for (int s = 0; s < 2; s++) begin
      t_c = 80 + 10 * s;
      mrs(3'h2, 16'(s << 7));
      // Hot self-refresh only once temperature mode is set; never above 95 C
      if (t_c <= 95 && (t_c <= 85 || s == 1)) SELF_REFRESH_I <= 1'b1;
      ct[s] = 0;
      repeat (96) @(posedge CLOCK_I) if (SELF_REFRESH_TICK_O === 1'b1) ct[s]++;
      SELF_REFRESH_I <= 1'b0;
    end
    chk("tick_1x", 16'h1, 16'(ct[0] inside {[9:13]}));
    chk("tick_2x", 16'h1, 16'(ct[1] inside {[17:26]}));
    $display("test self_refresh done, refresh every %0d ns", refi_ns(t_c));
    close_out();
  end
endmodule : dram_mode_register_decode_test
